// ===== verification/test_ufs_core.sv
// Self-checking bench for the USB function status block.
// Assumes ufs_pkg, ufs_sie_model and the checker are compiled first.
`timescale 1ns/1ps
module test_ufs_core;
    logic mclk_i = 1'b0;
    logic rst = 1'b1;
    logic ufr = 1'b0;
    logic pen = 1'b0;
    logic [49:0] req = 50'h0;
    logic [2:0] pins = 3'h0;
    logic [31:0] prdata, rdat;
    logic pready, perr, rerr, eirq, xirq;
    ufs_pkg::ufs_event_type ev;
    ufs_pkg::ufs_ep0_rpt_type rp;
    ufs_pkg::ufs_ctrl_type ctrl;
    int failures = 0;
    int comparisons = 0;
    int adr, sta, msk, d, n;
    ufs_sie_model ufs_sie_model_i (.mclk_i(mclk_i), .sie_event_o(ev), .ep0_rpt_o(rp));
    ufs_core ufs_core_i (.mclk_i(mclk_i), .sys_rst_i(rst), .usb_func_rst_i(ufr), .psel_i(req[49]),
        .penable_i(pen), .pwrite_i(req[48]), .paddr_i(req[47:36]), .pwdata_i(req[35:4]), .pstrb_i(req[3:0]),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr), .sie_event_i(ev), .wake_pin_i(pins[0]),
        .ring1_pin_i(pins[1]), .ring2_pin_i(pins[2]), .ep0_rpt_i(rp), .ctrl_o(ctrl), .event_irq_o(eirq),
        .xfer_irq_o(xirq));
    always #2.5 mclk_i = ~mclk_i;
    // ----
    // Tasks
    // ----
    task automatic conclude();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
        int k;
        k = 0;
        @(posedge mclk_i);
        req <= {1'b1, w, a, v, s};
        @(posedge mclk_i);
        pen <= 1'b1;
        do begin
            @(posedge mclk_i);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) begin
            failures++;
            conclude();
        end
        rdat = prdata;
        rerr = perr;
        req <= 50'h0;
        pen <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input int e, input string nm);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(nm, e, rdat);
    endtask
    task automatic wr(input logic [11:0] a, input int v);
        apb(1'b1, a, v, 4'hf);
    endtask
    initial begin
        repeat (20000) @(posedge mclk_i);
        failures++;
        conclude();
    end
    // ----
    // Scenarios
    // ----
    initial begin
        void'($urandom(32'hcb2a));
        repeat (12) @(posedge mclk_i);
        rst <= 1'b0;
        rd(12'h000, 0, "addr");
        rd(12'h004, 0, "status");
        rd(12'h008, 0, "mask");
        rd(12'h00c, 0, "config");
        rd(12'h010, 0, "unmapped");
        chk("slverr", 1, rerr);
        d = $urandom;
        wr(12'h000, d);
        adr = d & 8'h7f;
        rd(12'h000, adr, "addr");
        chk("device address", adr, ctrl.device_address);
        apb(1'b1, 12'h000, ~d, 4'h0);
        rd(12'h000, adr, "addr strobe");
        sta = 0;
        for (int i = 0; i < 8; i++) begin
            ufs_sie_model_i.evt(8'h01 << i);
            sta |= 1 << i;
            rd(12'h004, sta, "status set");
        end
        chk("force nak", 1, ctrl.ep0_force_nak);
        msk = $urandom & 8'hff;
        wr(12'h008, msk);
        rd(12'h008, msk, "mask");
        chk("event irq", (sta & msk) != 0, eirq);
        d = $urandom & 8'hff;
        wr(12'h004, d);
        sta = sta & ~d;
        rd(12'h004, sta, "status clear");
        chk("event irq", (sta & msk) != 0, eirq);
        chk("force nak", (sta >> 2) & 1, ctrl.ep0_force_nak);
        wr(12'h004, 32'hff);
        fork
            apb(1'b1, 12'h004, 32'h20, 4'h1);
            begin
                @(posedge mclk_i);
                ufs_sie_model_i.evt(8'h20);
            end
        join
        rd(12'h004, 32'h20, "set beats clear");
        ufs_sie_model_i.evt(8'h80);
        @(posedge mclk_i);
        ufr <= 1'b1;
        @(posedge mclk_i);
        ufr <= 1'b0;
        rd(12'h004, 32'h80, "func reset");
        rd(12'h000, 0, "addr cleared");
        wr(12'h00c, 32'hff);
        rd(12'h00c, 32'h8c, "config");
        chk("bm enable", 1, ctrl.ep0_bm_enable);
        chk("stall out", 1, ctrl.ep0_stall);
        ufs_sie_model_i.rpt(4'h8);
        rd(12'h00c, 32'h84, "stall auto");
        chk("stall out", 0, ctrl.ep0_stall);
        ufs_sie_model_i.rpt(4'h2);
        wr(12'h00c, 32'h84);
        rd(12'h00c, 32'ha4, "toggle ro");
        chk("toggle out", 1, ctrl.ep0_data_toggle);
        ufs_sie_model_i.rpt(4'h1);
        rd(12'h00c, 32'h84, "toggle clear");
        chk("toggle out", 0, ctrl.ep0_data_toggle);
        for (int en = 1; en >= 0; en--) begin
            wr(12'h00c, en << 2);
            n = 0;
            fork
                ufs_sie_model_i.rpt(4'h4);
                repeat (5) begin
                    @(posedge mclk_i);
                    n += int'(xirq);
                end
            join
            chk("xfer irq", en, n);
        end
        @(posedge mclk_i);
        pins <= 3'h7;
        repeat (8) @(posedge mclk_i);
        pins <= 3'h0;
        rd(12'h004, 32'h9a, "pin events");
        conclude();
    end
endmodule

// ===== verification/ufs_core_asserts.sv
// Port-level assertions for the USB function status block.
// Assumes the ufs_core port list; attached by the bind below.
`timescale 1ns/1ps
`include "ufs_params.svh"
module ufs_core_asserts (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic usb_func_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [`UFS_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic pslverr_o,
    input wire ufs_pkg::ufs_event_type sie_event_i,
    input wire ufs_pkg::ufs_ep0_rpt_type ep0_rpt_i,
    input wire ufs_pkg::ufs_ctrl_type ctrl_o,
    input wire logic event_irq_o,
    input wire logic xfer_irq_o
);
    // ----
    // Checks
    // ----
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);
    // Function reset clears most state, so it stays out of antecedents
    wire logic acc = psel_i && penable_i;
    wire logic wr = acc && pwrite_i && pstrb_i[0] && !usb_func_rst_i;
    a_addr_write: assert property (wr && paddr_i == `UFS_OFF_FUNC_ADDR
        |=> ctrl_o.device_address == $past(pwdata_i[6:0])) else $error("addr write");
    a_cfg_write: assert property (wr && paddr_i == `UFS_OFF_EP0_OUT_CFG && !ep0_rpt_i.stall_sent
        |=> ctrl_o.ep0_bm_enable == $past(pwdata_i[7]) && ctrl_o.ep0_stall == $past(pwdata_i[3]))
        else $error("cfg write");
    a_stall_auto: assert property (ep0_rpt_i.stall_sent |=> !ctrl_o.ep0_stall) else $error("stall");
    a_setup_nak: assert property (sie_event_i.setup && !usb_func_rst_i
        |=> ctrl_o.ep0_force_nak) else $error("nak");
    a_toggle_clr: assert property (ep0_rpt_i.toggle_clear |=> !ctrl_o.ep0_data_toggle) else $error("tgl");
    a_toggle_flip: assert property (ep0_rpt_i.toggle_flip && !ep0_rpt_i.toggle_clear && !usb_func_rst_i
        |=> ctrl_o.ep0_data_toggle != $past(ctrl_o.ep0_data_toggle)) else $error("flip");
    a_xfer_cause: assert property (xfer_irq_o |-> $past(ep0_rpt_i.xfer_done)) else $error("xfer");
    a_unmapped_err: assert property (acc && paddr_i > `UFS_OFF_EP0_OUT_CFG
        |-> pslverr_o && prdata_o == 32'h00000000) else $error("unmapped");
    a_upper_zero: assert property (acc && !pwrite_i |-> prdata_o[31:8] == 24'h000000) else $error("upper");
    a_reset_idle: assert property ($past(sys_rst_i)
        |-> !event_irq_o && ctrl_o == 11'h000) else $error("reset");
endmodule
bind ufs_core ufs_core_asserts ufs_core_asserts_i (.mclk_i, .sys_rst_i, .usb_func_rst_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pslverr_o, .sie_event_i, .ep0_rpt_i, .ctrl_o,
    .event_irq_o, .xfer_irq_o);

// ===== verification/ufs_sie_model.sv
// Engine-side model: link event strobes and endpoint-0 reports.
// Assumes the bench calls its tasks; one clock.
`timescale 1ns/1ps
module ufs_sie_model (
    input wire logic mclk_i,
    output ufs_pkg::ufs_event_type sie_event_o,
    output ufs_pkg::ufs_ep0_rpt_type ep0_rpt_o
);
    // ----
    // Strobes, one cycle wide
    // ----
    initial begin
        sie_event_o = 8'h00;
        ep0_rpt_o = 4'h0;
    end
    // Status bit i is struct bit 7-i, hence the reversal
    task automatic evt(input logic [7:0] e);
        @(posedge mclk_i);
        sie_event_o <= {<<{e}};
        @(posedge mclk_i);
        sie_event_o <= 8'h00;
    endtask
    task automatic rpt(input logic [3:0] r);
        @(posedge mclk_i);
        ep0_rpt_o <= r;
        @(posedge mclk_i);
        ep0_rpt_o <= 4'h0;
    endtask
endmodule

// ===== verilog/ufs_core.sv
// USB function status block: device address, event status with mask, endpoint-0 output configuration.
// Assumes an APB master on mclk_i, engine strobes on the same clock, and wake/ring pins that are asynchronous.
`timescale 1ns/1ps
`include "ufs_params.svh"

// Overview of operation
// (R01) Hold a 7-bit device address in bits 6..0 and drive it as current address.
// (R02) Microcontroller writes the new address after the host's set-address request.
// (R03) Status flags set only by hardware; write one clears, zero keeps; reset to zero.
// (R04) Each flag raises the interrupt while set and its mask bit is enabled.
// (R05) Bit 0 sets when a setup packet arrives over an unread one.
// (R06) Bit 1 sets on a remote wake-up request from the wake-up pin.
// (R07) Bit 2 sets on setup; while set, endpoint 0 IN and OUT are NAKed.
// (R08) Bits 3 and 4 set on ring detect of serial port one and two.
// (R09) Bit 5 sets when a function resume is detected on the bus.
// (R10) Bit 6 sets on global or selective suspend of the function.
// (R11) Bit 7 sets on host port reset; USB function reset does not clear it.
// (R12) Config bit 2 enables the endpoint-0 output completion interrupt.
// (R13) Stall bit 3 makes the endpoint answer STALL, then clears itself.
// (R14) Read-only bit 5 shows the endpoint-0 output DATA0/DATA1 toggle.
// (R15) Bit 7 lets the buffer manager use the endpoint; config resets to zero.
// (R16) Mask register has one enable per flag at equal positions, reset zero.
// (R17) Reserved bits read zero and ignore writes.
// (R18) Hardware set beats a same-cycle write-one clear.
module ufs_core (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic usb_func_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [`UFS_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire ufs_pkg::ufs_event_type sie_event_i,
    input wire logic wake_pin_i,
    input wire logic ring1_pin_i,
    input wire logic ring2_pin_i,
    input wire ufs_pkg::ufs_ep0_rpt_type ep0_rpt_i,
    output ufs_pkg::ufs_ctrl_type ctrl_o,
    output logic event_irq_o,
    output logic xfer_irq_o
);

    ufs_pkg::ufs_regs_type state_reg;
    ufs_pkg::ufs_regs_type state_next;
    logic [`UFS_BYTE_W-1:0] pin_rise;
    logic [`UFS_BYTE_W-1:0] hw_set;
    logic [`UFS_BYTE_W-1:0] w1c;
    logic wr_acc;
    logic rd_acc;
    logic hit;
    logic [31:0] rdata;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic addr_known(input logic [`UFS_ADDR_W-1:0] a);
        addr_known = (a == `UFS_OFF_FUNC_ADDR) || (a == `UFS_OFF_EVT_STATUS) ||
            (a == `UFS_OFF_EVT_MASK) || (a == `UFS_OFF_EP0_OUT_CFG);
    endfunction

    // Merge written byte under a write mask, keeping the other bits
    function automatic logic [`UFS_BYTE_W-1:0] merge(input logic [`UFS_BYTE_W-1:0] old,
            input logic [`UFS_BYTE_W-1:0] wd, input logic [`UFS_BYTE_W-1:0] m);
        merge = (old & ~m) | (wd & m);
    endfunction

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    ufs_pin_sync u_sync (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i({5'h00, ring2_pin_i, ring1_pin_i, wake_pin_i}),
        .rise_o(pin_rise)
    );

    // ----------------------------------------
    // Event sources
    // ----------------------------------------
    always_comb begin
        hw_set = `UFS_BYTE_ZERO;
        hw_set[`UFS_EVT_SETUP_OVW] = sie_event_i.setup_ovw; // see (R05)
        hw_set[`UFS_EVT_WAKE] = pin_rise[0] | sie_event_i.wake; // see (R06)
        hw_set[`UFS_EVT_SETUP] = sie_event_i.setup; // see (R07)
        hw_set[`UFS_EVT_RING1] = pin_rise[1] | sie_event_i.ring1; // see (R08)
        hw_set[`UFS_EVT_RING2] = pin_rise[2] | sie_event_i.ring2; // see (R08)
        hw_set[`UFS_EVT_RESUME] = sie_event_i.resume; // see (R09)
        hw_set[`UFS_EVT_SUSPEND] = sie_event_i.suspend; // see (R10)
        hw_set[`UFS_EVT_BUS_RESET] = sie_event_i.bus_reset; // see (R11)
    end

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    // Zero wait states; one write strobe lane carries every register
    assign hit = addr_known(paddr_i);
    assign wr_acc = psel_i & penable_i & pwrite_i & hit & pstrb_i[0];
    assign rd_acc = psel_i & penable_i & ~pwrite_i;
    assign w1c = (wr_acc && paddr_i == `UFS_OFF_EVT_STATUS) ? pwdata_i[`UFS_BYTE_W-1:0] : `UFS_BYTE_ZERO;

    always_comb begin
        rdata = `UFS_WORD_ZERO;
        unique case (paddr_i)
            `UFS_OFF_FUNC_ADDR: rdata[`UFS_BYTE_W-1:0] = state_reg.addr & `UFS_ADDR_MASK; // see (R17)
            `UFS_OFF_EVT_STATUS: rdata[`UFS_BYTE_W-1:0] = state_reg.status;
            `UFS_OFF_EVT_MASK: rdata[`UFS_BYTE_W-1:0] = state_reg.mask;
            `UFS_OFF_EP0_OUT_CFG: rdata[`UFS_BYTE_W-1:0] = state_reg.cfg; // see (R14)
            default: rdata = `UFS_WORD_ZERO;
        endcase
    end

    // ----------------------------------------
    // Register update
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        // Set wins over clear so no event is lost
        state_next.status = (state_reg.status & ~w1c) | hw_set; // see (R03) see (R18)
        if (wr_acc && paddr_i == `UFS_OFF_FUNC_ADDR) begin
            state_next.addr = merge(state_reg.addr, pwdata_i[`UFS_BYTE_W-1:0], `UFS_ADDR_MASK); // see (R01) see (R02)
        end
        if (wr_acc && paddr_i == `UFS_OFF_EVT_MASK) begin
            state_next.mask = pwdata_i[`UFS_BYTE_W-1:0]; // see (R16)
        end
        if (wr_acc && paddr_i == `UFS_OFF_EP0_OUT_CFG) begin
            state_next.cfg = merge(state_reg.cfg, pwdata_i[`UFS_BYTE_W-1:0], `UFS_CFG_WR_MASK); // see (R15) see (R17)
        end
        // Engine reports after software write, so a sent STALL is not re-armed late
        if (ep0_rpt_i.stall_sent) begin
            state_next.cfg[`UFS_CFG_STALL] = 1'b0; // see (R13)
        end
        if (ep0_rpt_i.toggle_clear) begin
            state_next.cfg[`UFS_CFG_TOGGLE] = 1'b0; // see (R14)
        end else if (ep0_rpt_i.toggle_flip) begin
            state_next.cfg[`UFS_CFG_TOGGLE] = ~state_reg.cfg[`UFS_CFG_TOGGLE]; // see (R14)
        end
        state_next.xfer_irq = ep0_rpt_i.xfer_done & state_reg.cfg[`UFS_CFG_IRQ_EN]; // see (R12)
    end

    // ----------------------------------------
    // State registers
    // ----------------------------------------
    // USB function reset spares the bus-reset flag and clears the address along with the rest
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            state_reg <= '0;
        end else if (usb_func_rst_i) begin
            state_reg <= '0;
            state_reg.addr <= `UFS_BYTE_ZERO;
            state_reg.status[`UFS_EVT_BUS_RESET] <= state_next.status[`UFS_EVT_BUS_RESET]; // see (R11)
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~hit;
    assign prdata_o = rd_acc ? rdata : `UFS_WORD_ZERO;
    assign event_irq_o = |(state_reg.status & state_reg.mask); // see (R04)
    assign xfer_irq_o = state_reg.xfer_irq;

    always_comb begin
        ctrl_o.device_address = state_reg.addr[6:0]; // see (R01)
        ctrl_o.ep0_force_nak = state_reg.status[`UFS_EVT_SETUP]; // see (R07)
        ctrl_o.ep0_stall = state_reg.cfg[`UFS_CFG_STALL]; // see (R13)
        ctrl_o.ep0_bm_enable = state_reg.cfg[`UFS_CFG_BM_EN]; // see (R15)
        ctrl_o.ep0_data_toggle = state_reg.cfg[`UFS_CFG_TOGGLE];
    end

endmodule

// ===== verilog/ufs_params.svh
// Register offsets, field positions and reset values for the USB function status block.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef UFS_PARAMS_SVH
`define UFS_PARAMS_SVH

// ----------------------------------------
// Register byte offsets (APB, 32-bit words)
// ----------------------------------------
`define UFS_OFF_FUNC_ADDR 12'h000
`define UFS_OFF_EVT_STATUS 12'h004
`define UFS_OFF_EVT_MASK 12'h008
`define UFS_OFF_EP0_OUT_CFG 12'h00c
`define UFS_ADDR_W 12

// ----------------------------------------
// Field positions
// ----------------------------------------
`define UFS_EVT_SETUP_OVW 0
`define UFS_EVT_WAKE 1
`define UFS_EVT_SETUP 2
`define UFS_EVT_RING1 3
`define UFS_EVT_RING2 4
`define UFS_EVT_RESUME 5
`define UFS_EVT_SUSPEND 6
`define UFS_EVT_BUS_RESET 7
`define UFS_CFG_IRQ_EN 2
`define UFS_CFG_STALL 3
`define UFS_CFG_TOGGLE 5
`define UFS_CFG_BM_EN 7

// ----------------------------------------
// Masks and reset values
// ----------------------------------------
`define UFS_ADDR_MASK 8'h7f
`define UFS_CFG_WR_MASK 8'h8c
`define UFS_BYTE_ZERO 8'h00
`define UFS_WORD_ZERO 32'h00000000
`define UFS_BYTE_W 8

`endif

// ===== verilog/ufs_pin_sync.sv
// Three-stage synchroniser with agreement-based edge detect for asynchronous event pins.
// Assumes each pin is a level that stays high at least three clock cycles per event.
`timescale 1ns/1ps
`include "ufs_params.svh"

module ufs_pin_sync (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic [`UFS_BYTE_W-1:0] pin_i,
    output logic [`UFS_BYTE_W-1:0] rise_o
);

    ufs_pkg::ufs_sync_type state_reg;
    ufs_pkg::ufs_sync_type state_next;

    // ----------------------------------------
    // Stage chain
    // ----------------------------------------
    // First stage feeds only the second; change counts when second and third agree
    always_comb begin
        state_next = state_reg;
        state_next.q1 = pin_i;
        state_next.q2 = state_reg.q1;
        state_next.q3 = state_reg.q2;
        state_next.seen = (state_reg.q2 == state_reg.q3) ? state_reg.q3 : state_reg.seen;
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rise_o = state_next.seen & ~state_reg.seen;

endmodule

// ===== verilog/ufs_pkg.sv
// Types shared by the USB function status block.
// Assumes ufs_params.svh is available on the include path.
`include "ufs_params.svh"

package ufs_pkg;

    // Link-side event strobes from the serial interface engine
    typedef struct packed {
        logic setup_ovw;
        logic wake;
        logic setup;
        logic ring1;
        logic ring2;
        logic resume;
        logic suspend;
        logic bus_reset;
    } ufs_event_type;

    // Endpoint-0 output transaction reports from the engine
    typedef struct packed {
        logic stall_sent;
        logic xfer_done;
        logic toggle_flip;
        logic toggle_clear;
    } ufs_ep0_rpt_type;

    // Controls back to the engine
    typedef struct packed {
        logic [6:0] device_address;
        logic ep0_force_nak;
        logic ep0_stall;
        logic ep0_bm_enable;
        logic ep0_data_toggle;
    } ufs_ctrl_type;

    typedef struct packed {
        logic [`UFS_BYTE_W-1:0] addr;
        logic [`UFS_BYTE_W-1:0] status;
        logic [`UFS_BYTE_W-1:0] mask;
        logic [`UFS_BYTE_W-1:0] cfg;
        logic xfer_irq;
    } ufs_regs_type;

    typedef struct packed {
        logic [`UFS_BYTE_W-1:0] q1;
        logic [`UFS_BYTE_W-1:0] q2;
        logic [`UFS_BYTE_W-1:0] q3;
        logic [`UFS_BYTE_W-1:0] seen;
    } ufs_sync_type;

endpackage
